// file: include/ard_regs.svh
/*
 * register offsets, entry field positions and reset values for one
 * redirection entry with its delivery-kind and vector decode.
 * assumes a 32-bit avalon-mm slave port with word addressing (byte/4).
 */
// Behaviour
// - entry bits 10:8 hold the three-bit delivery kind field.
// - kind 000 fixed: normal interrupt to every destination, edge or level.
// - kind 001 lowest priority: one lowest-priority destination, edge or level.
// - system management kind ignores vector; software should write zero vector.
// - kind 100 sends non-maskable interrupt to all destinations, vector ignored.
// - kind 101 sends initialization to all destinations.
// - kind 111 external controller; acknowledge cycle routed to that controller.
// - bits 7:0 are a read/write vector number field.
// - bit 15 trigger type: one level, zero edge.
// - mask bit 16 set ignores input events; clear delivers them.
// - read-only bit 12 shows a send pending while delivery is held up.
// - bit 11 selects physical four-bit or logical eight-bit destination.
`ifndef ARD_REGS_SVH
`define ARD_REGS_SVH
`define ARD_OFF_LOW     4'h0
`define ARD_OFF_HIGH    4'h1
`define ARD_OFF_STAT    4'h2
`define ARD_VEC_LSB     0
`define ARD_VEC_MSB     7
`define ARD_KIND_LSB    8
`define ARD_KIND_MSB    10
`define ARD_DMODE_BIT   11
`define ARD_PEND_BIT    12
`define ARD_POL_BIT     13
`define ARD_TRIG_BIT    15
`define ARD_MASK_BIT    16
`define ARD_DEST_LSB    24
`define ARD_DEST_MSB    31
`define ARD_PHYS_MSB    27
`define ARD_LOW_WMASK   32'h0001_AFFF
`define ARD_LOW_RESET   32'h0001_0000
`define ARD_HIGH_WMASK  32'hFF00_0000
`define ARD_KIND_FIXED  3'h0
`define ARD_KIND_LOWPRI 3'h1
`define ARD_KIND_SMGMT  3'h2
`define ARD_KIND_NMI    3'h4
`define ARD_KIND_INIT   3'h5
`define ARD_KIND_EXT    3'h7
`endif

// file: include/ard_pkg.sv
/*
 * types for the redirection entry delivery block.
 * assumes ard_regs.svh supplies the numeric constants.
 */
package ard_pkg;
   typedef enum logic [2:0] {
      ARD_DK_FIXED, ARD_DK_LOWPRI, ARD_DK_SMGMT, ARD_DK_RSV3,
      ARD_DK_NMI, ARD_DK_INIT, ARD_DK_RSV6, ARD_DK_EXT
   } ard_kind_t;

   // one delivery message handed to the processor side
   typedef struct packed {
      logic [7:0] dest;       // physical id in 3:0 or logical address
      logic       logical;    // destination interpretation bit
      logic [7:0] vector;     // zero where the kind ignores it
      logic       level;      // trigger type carried along
      logic       to_int;     // normal interrupt input
      logic       to_nmi;     // non-maskable input
      logic       to_init;    // initialization assertion
      logic       to_smgmt;   // system management input
      logic       lowest;     // only the lowest-priority processor
      logic       ext_ack;    // acknowledge cycle goes to external controller
   } ard_msg_t;

   typedef enum logic [1:0] {ARD_IDLE, ARD_SEND} ard_state_t;
endpackage

// file: hdl/ard_redirect.sv
/*
 * one redirection entry: avalon-mm register access, input event capture,
 * delivery-kind decode and a held message to the local interrupt units.
 * assumes irq_i is an asynchronous pin and the message sink answers with
 * msg_accept_i on the same clock.
 */
// Our own choices: the Avalon-MM interface to the registers and the address map.
`include "ard_regs.svh"
module ard_redirect
   import ard_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic          reset_i,
   input  wire logic [3:0]    avs_address_i,
   input  wire logic          avs_read_i,
   input  wire logic          avs_write_i,
   input  wire logic [31:0]   avs_writedata_i,
   input  wire logic [3:0]    avs_byteenable_i,
   output logic [31:0]        avs_readdata_o,
   output logic               avs_waitrequest_o,
   output logic [1:0]         avs_response_o,
   input  wire logic          irq_i,
   output ard_msg_t           msg_o,
   output logic               msg_valid_o,
   input  wire logic          msg_accept_i
);

   logic [31:0] entry_low, next_entry_low;
   logic [31:0] entry_high, next_entry_high;
   logic [31:0] rdata, next_rdata;
   logic        ack, next_ack;
   logic [1:0]  resp, next_resp;
   logic        sync1, sync2, irq_prev;
   logic        raw_req;
   ard_state_t  state, next_state;
   ard_msg_t    msg, next_msg;
   logic [7:0]  sent_cnt, next_sent_cnt;
   logic        wreq, next_wreq;    // registered waitrequest
   logic        valid, next_valid;  // registered send pending

   // byte-enable merge of a write into the stored word
   // bits outside the write mask keep their stored value
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be,
                                         input logic [31:0] wm);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
      merge = (old & ~m) | (wd & m);
   endfunction

   // build the message for the programmed delivery kind
   function automatic ard_msg_t build(input logic [31:0] lo,
                                      input logic [31:0] hi);
      ard_msg_t   m;
      logic [2:0] k;
      m = '0;
      k = lo[`ARD_KIND_MSB:`ARD_KIND_LSB];
      m.logical = lo[`ARD_DMODE_BIT];
      m.dest    = lo[`ARD_DMODE_BIT] ? hi[`ARD_DEST_MSB:`ARD_DEST_LSB]
                : {4'h0, hi[`ARD_PHYS_MSB:`ARD_DEST_LSB]};
      m.level   = lo[`ARD_TRIG_BIT];
      m.vector  = lo[`ARD_VEC_MSB:`ARD_VEC_LSB];
      // each kind picks one input; reserved kinds pick none
      unique case (k)
         `ARD_KIND_FIXED:  m.to_int = 1'b1;
         `ARD_KIND_LOWPRI: begin
            m.to_int = 1'b1;
            m.lowest = 1'b1;
         end
         `ARD_KIND_SMGMT: begin
            m.to_smgmt = 1'b1;
            m.vector   = 8'h00;
         end
         `ARD_KIND_NMI: begin
            m.to_nmi = 1'b1;
            m.vector = 8'h00;
         end
         `ARD_KIND_INIT: begin
            m.to_init = 1'b1;
            m.vector  = 8'h00;
         end
         `ARD_KIND_EXT: begin
            m.to_int  = 1'b1;
            m.ext_ack = 1'b1;
            m.vector  = 8'h00;  // external controller supplies it
         end
         default: m.to_int = 1'b0;  // reserved kinds deliver nothing
      endcase
      build = m;
   endfunction

   // pin synchroniser and edge memory
   // only sync2 and irq_prev feed logic: sync1 may still be settling
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sync1    <= 1'b0;
         sync2    <= 1'b0;
         irq_prev <= 1'b0;
      end else begin
         sync1    <= irq_i;
         sync2    <= sync1;
         irq_prev <= sync2;
      end
   end

   // polarity, trigger type and mask give the request
   // level mode asks while active, edge mode only on a fresh edge
   always_comb begin
      logic act;
      logic act_prev;
      act      = sync2 ^ entry_low[`ARD_POL_BIT];
      act_prev = irq_prev ^ entry_low[`ARD_POL_BIT];
      raw_req  = entry_low[`ARD_TRIG_BIT] ? act : (act & ~act_prev);
      if (entry_low[`ARD_MASK_BIT])
         raw_req = 1'b0;
   end

   // bus slave and entry storage, next values
   // ack blocks a second take of a request still held in its answer cycle
   always_comb begin
      next_entry_low  = entry_low;
      next_entry_high = entry_high;
      next_rdata      = rdata;
      next_resp       = resp;
      next_ack        = 1'b0;
      next_wreq       = 1'b1;
      if ((avs_read_i || avs_write_i) && !ack) begin
         next_ack   = 1'b1;
         next_wreq  = 1'b0;
         next_resp  = 2'b00;
         next_rdata = 32'h0000_0000;
         unique case (avs_address_i)
            `ARD_OFF_LOW: begin
               next_rdata = entry_low;
               next_rdata[`ARD_PEND_BIT] = (state == ARD_SEND);
            end
            `ARD_OFF_HIGH: next_rdata = entry_high;
            `ARD_OFF_STAT: next_rdata = {24'h00_0000, sent_cnt};
            default:       next_resp  = 2'b10;  // slave error, reads zero
         endcase
      end
      // a write lands at the edge where the master sees waitrequest low
      if (ack && avs_write_i) begin
         if (avs_address_i == `ARD_OFF_LOW)
            next_entry_low = merge(entry_low, avs_writedata_i,
                                   avs_byteenable_i, `ARD_LOW_WMASK);
         if (avs_address_i == `ARD_OFF_HIGH)
            next_entry_high = merge(entry_high, avs_writedata_i,
                                    avs_byteenable_i, `ARD_HIGH_WMASK);
      end
   end

   // bus registers; waitrequest has its own flop, high out of reset
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         entry_low  <= `ARD_LOW_RESET;
         entry_high <= 32'h0000_0000;
         rdata      <= 32'h0000_0000;
         resp       <= 2'b00;
         ack        <= 1'b0;
         wreq       <= 1'b1;
      end else begin
         entry_low  <= next_entry_low;
         entry_high <= next_entry_high;
         rdata      <= next_rdata;
         resp       <= next_resp;
         ack        <= next_ack;
         wreq       <= next_wreq;
      end
   end

   // bus ports straight from registers
   assign avs_readdata_o    = rdata;
   assign avs_response_o    = resp;
   assign avs_waitrequest_o = wreq;

   // delivery sequencer: hold the message until the sink takes it
   // an edge seen while a message is pending is dropped, not queued
   always_comb begin
      next_state    = state;
      next_msg      = msg;
      next_sent_cnt = sent_cnt;
      unique case (state)
         ARD_IDLE: begin
            if (raw_req) begin
               next_msg   = build(entry_low, entry_high);
               next_state = (next_msg.to_int | next_msg.to_nmi |
                             next_msg.to_init | next_msg.to_smgmt)
                            ? ARD_SEND : ARD_IDLE;
            end
         end
         ARD_SEND: begin
            if (msg_accept_i) begin
               next_state    = ARD_IDLE;
               next_sent_cnt = sent_cnt + 8'h01;
            end
         end
         default: next_state = ARD_IDLE;
      endcase
      next_valid = (next_state == ARD_SEND);
   end

   // sequencer registers; valid is its own flop so the port needs no decode
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state    <= ARD_IDLE;
         msg      <= '0;
         sent_cnt <= 8'h00;
         valid    <= 1'b0;
      end else begin
         state    <= next_state;
         msg      <= next_msg;
         sent_cnt <= next_sent_cnt;
         valid    <= next_valid;
      end
   end

   // message ports straight from registers
   assign msg_o       = msg;
   assign msg_valid_o = valid;

endmodule

// file: bench/ard_redirect_chk.sv
/* port checker for ard_redirect.
   assumes the bind below and one clock. */
module ard_redirect_chk
   import ard_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        reset_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   input wire logic [1:0]  avs_response_o,
   input wire ard_msg_t    msg_o,
   input wire logic        msg_valid_o,
   input wire logic        msg_accept_i
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   a_wait_one: assert property (!avs_waitrequest_o |=>
      avs_waitrequest_o)
      else $error("wait low twice");
   a_bus_answer: assert property ((avs_read_i || avs_write_i) &&
      avs_waitrequest_o |-> ##[1:2] !avs_waitrequest_o)
      else $error("no answer");
   a_bad_read: assert property (!avs_waitrequest_o &&
      avs_response_o == 2'h2 |-> avs_readdata_o == 32'h0)
      else $error("unmapped data");
   a_msg_hold: assert property (msg_valid_o && !msg_accept_i |=>
      msg_valid_o && $stable(msg_o))
      else $error("message moved");
   a_edge_take: assert property (msg_valid_o && msg_accept_i &&
      !msg_o.level |=> !msg_valid_o)
      else $error("pending stuck");
   a_vec_zero: assert property (msg_valid_o && (msg_o.to_nmi ||
      msg_o.to_init || msg_o.to_smgmt || msg_o.ext_ack) |->
      msg_o.vector == 8'h0)
      else $error("vector kept");
   a_one_input: assert property (msg_valid_o |->
      $onehot({msg_o.to_int, msg_o.to_nmi, msg_o.to_init, msg_o.to_smgmt}))
      else $error("inputs");
   a_int_route: assert property (msg_valid_o && (msg_o.lowest ||
      msg_o.ext_ack) |-> msg_o.to_int)
      else $error("route");
endmodule

bind ard_redirect ard_redirect_chk ard_redirect_chk_inst (
   .clk_i(clk_i), .reset_i(reset_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
   .msg_o(msg_o), .msg_valid_o(msg_valid_o), .msg_accept_i(msg_accept_i)
);

// file: bench/ard_sink_model.sv
/* local interrupt units taking one message at a time.
   assumes msg_valid_i from ard_redirect on clk_i. */
module ard_sink_model (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic [3:0] dly_i,
   input  wire logic       msg_valid_i,
   output logic            msg_accept_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt;
   // refuse for dly_i + 1 cycles, then accept for one cycle
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt <= 4'h0;
         msg_accept_o <= 1'h0;
      end else begin
         msg_accept_o <= msg_valid_i && !msg_accept_o
                         && cnt >= dly_i;
         cnt <= (msg_valid_i && !msg_accept_o) ? cnt + 4'h1 : 4'h0;
      end
   end
endmodule

// file: bench/ard_redirect_test.sv
/* self-checking bench for ard_redirect.
   assumes ard_sink_model as the far side. */
module ard_redirect_test
   import ard_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 1'h0, reset_i = 1'h1, irq_i = 1'h0;
   logic        avs_read_i = 1'h0, avs_write_i = 1'h0, msg_accept_i;
   logic [3:0]  avs_address_i = 4'h0;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q, w;
   logic        avs_waitrequest_o, msg_valid_o;
   logic [1:0]  avs_response_o;
   logic [2:0]  k;
   logic [1:0]  r;
   logic [3:0]  be = 4'hF;
   ard_msg_t    msg_o, e;
   int          n_mismatch = 0, n_compared = 0, cyc = 0;
   ard_redirect ard_redirect_inst (.clk_i(clk_i), .reset_i(reset_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(be), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
      .irq_i(irq_i), .msg_o(msg_o), .msg_valid_o(msg_valid_o),
      .msg_accept_i(msg_accept_i));
   ard_sink_model ard_sink_model_inst (.clk_i(clk_i), .reset_i(reset_i),
      .dly_i(4'hC), .msg_valid_i(msg_valid_o), .msg_accept_o(msg_accept_i));
   // clock and hang guard
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         end_sim;
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      if (g !== x) begin
         n_mismatch++;
         $display("ERROR t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   // one bus cycle, held until waitrequest is seen low
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address_i <= a;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      avs_writedata_i <= d;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'h0);
      q = avs_readdata_o;
      r = avs_response_o;
      avs_write_i <= 1'h0;
      avs_read_i <= 1'h0;
      @(posedge clk_i);
   endtask
   task wait_v(input logic v);
      do @(posedge clk_i); while (msg_valid_o !== v);
   endtask
   // the six defined delivery kinds, edge triggered, pending flag read back
   task t_kinds;
      for (int i = 0; i < 6; i++) begin
         k = 3'(i + (i > 2) + (i > 4));
         w = {20'h0, k == 3'h7, k, k < 3'h2 ? 8'hFE : {3'h0, k != 3'h2, 4'h0}};
         bus(1'h1, 4'h0, w);
         irq_i <= 1'h1;
         wait_v(1'h1);
         e = '{dest: k == 3'h7 ? 8'hA5 : 8'h05, logical: k == 3'h7,
            vector: k < 3'h2 ? 8'hFE : 8'h0, level: 1'h0,
            to_int: k < 3'h2 || k == 3'h7, to_nmi: k == 3'h4,
            to_init: k == 3'h5, to_smgmt: k == 3'h2, lowest: k == 3'h1,
            ext_ack: k == 3'h7};
         chk(32'(msg_o), 32'(e));
         bus(1'h0, 4'h0, 32'h0);
         chk(q, w | 32'h1000);
         irq_i <= 1'h0;
         wait_v(1'h0);
      end
      $display("test kinds done");
   endtask
   // level re-delivery, then masked input gives nothing
   task t_level;
      bus(1'h1, 4'h0, 32'h0000_8040);
      irq_i <= 1'h1;
      wait_v(1'h1);
      chk(32'(msg_o.level), 32'h1);
      wait_v(1'h0);
      wait_v(1'h1);
      bus(1'h1, 4'h0, 32'h0001_8040);
      wait_v(1'h0);
      repeat (8) @(posedge clk_i);
      chk(32'(msg_valid_o), 32'h0);
      irq_i <= 1'h0;
      $display("test level done");
   endtask
   // reserved kind sends nothing; active-low pin delivers on its fall
   task t_odd;
      bus(1'h1, 4'h0, 32'h0000_0340);
      irq_i <= 1'h1;
      repeat (8) @(posedge clk_i);
      chk(32'(msg_valid_o), 32'h0);
      bus(1'h1, 4'h0, 32'h0000_2040);
      irq_i <= 1'h0;
      wait_v(1'h1);
      chk(32'({msg_o.vector, msg_o.to_int}), 32'h81);
      wait_v(1'h0);
      $display("test odd done");
   endtask
   task end_sim;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      reset_i <= 1'h0;
      @(posedge clk_i);
      bus(1'h0, 4'h0, 32'h0);
      chk(q, 32'h0001_0000);
      chk(32'(r), 32'h0);
      bus(1'h1, 4'h1, 32'hA500_0000);
      t_kinds;
      t_level;
      t_odd;
      be <= 4'h1;
      bus(1'h1, 4'h0, 32'hFFFF_FF77);
      be <= 4'hF;
      bus(1'h0, 4'h0, 32'h0);
      chk(q, 32'h0000_2077);
      bus(1'h1, 4'h5, 32'hFFFF_FFFF);
      chk(32'(r), 32'h2);
      bus(1'h0, 4'h5, 32'h0);
      chk(q, 32'h0);
      chk(32'(r), 32'h2);
      bus(1'h0, 4'h2, 32'h0);
      chk(q & 32'hFF, 32'h9);
      $display("test misc done");
      end_sim;
   end
endmodule
